// [verilog/bit_sync_defines.svh]
// Purpose: constants for the bit synchronisation loop gain configuration
// Assumes: 8-bit register reached over the device's serial configuration port
// Notes: gains are expressed in eighths of the base gain so that K/2 is exact
`ifndef BIT_SYNC_DEFINES_SVH
`define BIT_SYNC_DEFINES_SVH

// ============================================================
// register map
`define BIT_SYNC_CONFIG_ADDR   6'h1a
`define BIT_SYNC_CONFIG_RESET  8'h6c

// ============================================================
// field positions
`define PRE_KI_HI      7
`define PRE_KI_LO      6
`define PRE_KP_HI      5
`define PRE_KP_LO      4
`define POST_KI_BIT    3
`define POST_KP_BIT    2
`define LIMIT_HI       1
`define LIMIT_LO       0

// ============================================================
// gain scale: one base gain equals eight units
`define GAIN_ONE       6'h08
`define GAIN_HALF      6'h04

// ============================================================
// rate limit in units of 1/32 percent of nominal rate (3.125% = 100)
`define LIMIT_NONE     10'h000
`define LIMIT_3P125    10'h064
`define LIMIT_6P25     10'h0c8
`define LIMIT_12P5     10'h190

`endif

// [verilog/bit_sync_pkg.sv]
// Purpose: shared types for the bit synchronisation configuration block
// Assumes: nothing beyond the defines header
// Notes: none
`default_nettype none
package bit_sync_pkg;
    typedef logic [5:0] gain_t;
    typedef logic [9:0] limit_t;
    typedef enum logic [0:0] {
        SEARCH = 1'b0,
        LOCKED = 1'b1
    } sync_phase_e;
endpackage
`default_nettype wire

// [verilog/gain_select.sv]
// Purpose: turn register fields and sync phase into loop gains and rate clamp
// Assumes: combinational, fed from the config register flip-flops and the combinational next-phase decode
// Notes: gains in eighths of the base gain
`include "bit_sync_defines.svh"
`default_nettype none
module gain_select (
    input  wire logic [1:0]           pre_ki,
    input  wire logic [1:0]           pre_kp,
    input  wire logic                 post_ki,
    input  wire logic                 post_kp,
    input  wire logic [1:0]           limit_sel,
    input  wire logic                 locked,
    output logic      [5:0]           ki_gain,
    output logic      [5:0]           kp_gain,
    output logic      [9:0]           rate_limit
);
    // ============================================================
    // multiples of the base gain
    function automatic logic [5:0] multiple(input logic [1:0] code);
        logic [5:0] r;
        r = 6'h00;
        case (code)
            2'h0: r = `GAIN_ONE;
            2'h1: r = 6'(`GAIN_ONE * 2);
            2'h2: r = 6'(`GAIN_ONE * 3);
            2'h3: r = 6'(`GAIN_ONE * 4);
            default: r = `GAIN_ONE;
        endcase
        return r;
    endfunction

    always_comb begin
        ki_gain = multiple(pre_ki);
        kp_gain = multiple(pre_kp);
        if (locked && post_ki) begin
            ki_gain = `GAIN_HALF;
        end
        if (locked && post_kp) begin
            kp_gain = `GAIN_ONE;
        end
        case (limit_sel)
            2'h0: rate_limit = `LIMIT_NONE;
            2'h1: rate_limit = `LIMIT_3P125;
            2'h2: rate_limit = `LIMIT_6P25;
            2'h3: rate_limit = `LIMIT_12P5;
            default: rate_limit = `LIMIT_NONE;
        endcase
    end
endmodule // gain_select
`default_nettype wire

// [verilog/bit_sync_loop_gain_config.sv]
// Purpose: bit synchronisation loop configuration register and gain steering
// Assumes: register port address, data and write strobe are synchronous to ref_clk
// Notes: carrier sense arrives from outside this clock domain and is synchronised
`include "bit_sync_defines.svh"
`default_nettype none
module bit_sync_loop_gain_config (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic [5:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 loops_carrier_gate,
    input  wire logic                 carrier_sense,
    input  wire logic                 sync_detected,
    input  wire logic                 search_start,
    output logic      [5:0]           ki_gain,
    output logic      [5:0]           kp_gain,
    output logic      [9:0]           rate_limit,
    output logic                      loops_frozen,
    output logic                      post_sync_active
);
    // ============================================================
    // register field map
    //   [7:6] pre-sync integral code      [5:4] pre-sync proportional code
    //   [3]   post-sync integral select   [2]   post-sync proportional select
    //   [1:0] rate offset limit code

    // ============================================================
    // address decode
    // one decode serves both the write path and the read path
    function automatic logic hits_config(input logic [5:0] addr);
        return (addr == `BIT_SYNC_CONFIG_ADDR);
    endfunction

    // ============================================================
    // configuration register
    logic [7:0] bit_sync_config;
    logic       config_write;

    assign config_write = reg_wr && hits_config(reg_addr);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_sync_config <= `BIT_SYNC_CONFIG_RESET;
        end else if (config_write) begin
            bit_sync_config <= reg_wdata;
        end
    end

    // ============================================================
    // register read port
    // reads of other addresses return zero; only this register lives here
    // the answer is registered, so it trails the address by one cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (hits_config(reg_addr)) begin
            reg_rdata <= bit_sync_config;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ============================================================
    // register fields
    logic [1:0] pre_sync_integral_gain_sel;
    logic [1:0] pre_sync_proportional_gain_sel;
    logic       post_sync_integral_gain_sel;
    logic       post_sync_proportional_gain_sel;
    logic [1:0] rate_offset_limit;

    assign pre_sync_integral_gain_sel      = bit_sync_config[`PRE_KI_HI:`PRE_KI_LO];
    assign pre_sync_proportional_gain_sel  = bit_sync_config[`PRE_KP_HI:`PRE_KP_LO];
    assign post_sync_integral_gain_sel     = bit_sync_config[`POST_KI_BIT];
    assign post_sync_proportional_gain_sel = bit_sync_config[`POST_KP_BIT];
    assign rate_offset_limit               = bit_sync_config[`LIMIT_HI:`LIMIT_LO];

    // ============================================================
    // sync phase tracking
    // search: hunting for a sync word, pre-sync gains
    // locked: sync word found, post-sync selections apply
    bit_sync_pkg::sync_phase_e phase;
    bit_sync_pkg::sync_phase_e next_phase;
    logic                      new_search;

    // sync detect wins over a simultaneous search start so the event is not lost
    assign new_search = search_start && !sync_detected;

    always_comb begin
        next_phase = phase;
        case (phase)
            bit_sync_pkg::SEARCH: begin
                if (sync_detected) begin
                    next_phase = bit_sync_pkg::LOCKED;
                end
            end
            bit_sync_pkg::LOCKED: begin
                if (new_search) begin
                    next_phase = bit_sync_pkg::SEARCH;
                end
            end
            default: begin
                next_phase = bit_sync_pkg::SEARCH;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= bit_sync_pkg::SEARCH;
        end else begin
            phase <= next_phase;
        end
    end

    // gains follow the phase being entered, so the switch lands on the event cycle;
    // the price is a combinational path from the sync and search pulses to the gains
    logic locked;

    assign locked = (next_phase == bit_sync_pkg::LOCKED);

    // ============================================================
    // carrier sense synchroniser
    // carrier sense is not timed to ref_clk; only cs_sync may feed logic
    logic cs_meta;
    logic cs_sync;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_meta <= 1'b0;
            cs_sync <= 1'b0;
        end else begin
            cs_meta <= carrier_sense;
            cs_sync <= cs_meta;
        end
    end

    // ============================================================
    // loop freeze
    logic cs_seen;
    logic carrier_present;

    // once carrier is seen in a search the loops run until the next search;
    // carrier in the cycle of a search start still counts, so the set wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_seen <= 1'b0;
        end else if (cs_sync) begin
            cs_seen <= 1'b1;
        end else if (search_start) begin
            cs_seen <= 1'b0;
        end
    end

    assign carrier_present = cs_sync || cs_seen;

    // ============================================================
    // gain steering
    logic [5:0] next_ki;
    logic [5:0] next_kp;
    logic [9:0] next_limit;

    gain_select u_gain_select (
        .pre_ki     (pre_sync_integral_gain_sel),
        .pre_kp     (pre_sync_proportional_gain_sel),
        .post_ki    (post_sync_integral_gain_sel),
        .post_kp    (post_sync_proportional_gain_sel),
        .limit_sel  (rate_offset_limit),
        .locked     (locked),
        .ki_gain    (next_ki),
        .kp_gain    (next_kp),
        .rate_limit (next_limit)
    );

    // ============================================================
    // loop gain outputs
    // not registered here: a register would delay the switch past the sync event;
    // the loop filter that consumes them registers them on use
    assign ki_gain          = next_ki;
    assign kp_gain          = next_kp;

    // ============================================================
    // rate clamp output
    // zero limit means no rate compensation at all, not a tiny window
    assign rate_limit       = next_limit;

    // ============================================================
    // status outputs
    // post_sync_active is high in the sync cycle itself, matching the gains
    assign post_sync_active = locked;

    // the gate comes from another register on this clock, so it needs no sync
    assign loops_frozen     = loops_carrier_gate && !carrier_present;
endmodule // bit_sync_loop_gain_config
`default_nettype wire

// [sim/bit_sync_properties.sv]
// Purpose: port checks for the loop gain configuration block
// Assumes: gains in eighths of base, rate limit in 1/32 percent
// Notes: sees only the ports of the block it is bound into
`default_nettype none
module bit_sync_checker (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       loops_carrier_gate,
    input  wire logic       carrier_sense,
    input  wire logic       sync_detected,
    input  wire logic       search_start,
    input  wire logic [5:0] ki_gain,
    input  wire logic [5:0] kp_gain,
    input  wire logic [9:0] rate_limit,
    input  wire logic       loops_frozen,
    input  wire logic       post_sync_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic w = reg_wr && reg_addr == 6'h1a;
    a_pre_ki: assert property (w ##1 !post_sync_active |-> ki_gain == 6'(($past(reg_wdata[7:6]) + 1) * 8))
        else $error("pre-sync integral gain wrong");
    a_pre_kp: assert property (w ##1 !post_sync_active |-> kp_gain == 6'(($past(reg_wdata[5:4]) + 1) * 8))
        else $error("pre-sync proportional gain wrong");
    a_post_ki: assert property (w ##1 post_sync_active |-> ki_gain ==
        ($past(reg_wdata[3]) ? 6'h04 : 6'(($past(reg_wdata[7:6]) + 1) * 8))) else $error("post-sync integral gain wrong");
    a_post_kp: assert property (w ##1 post_sync_active |-> kp_gain ==
        ($past(reg_wdata[2]) ? 6'h08 : 6'(($past(reg_wdata[5:4]) + 1) * 8))) else $error("post-sync prop gain wrong");
    a_rate_clamp: assert property (w && reg_wdata[1:0] != 2'h0 |=> rate_limit == 10'(50 << $past(reg_wdata[1:0])))
        else $error("rate clamp wrong");
    a_rate_off: assert property (w && reg_wdata[1:0] == 2'h0 |=> rate_limit == 10'h000)
        else $error("rate clamp not zero");
    a_gate_hold: assert property ((loops_carrier_gate && !carrier_sense) [*3] ##0 search_start
        ##1 loops_carrier_gate |-> loops_frozen) else $error("loops not frozen");
    a_cs_release: assert property (carrier_sense [*3] |-> !loops_frozen)
        else $error("loops still frozen");
    a_sync_phase: assert property (sync_detected || search_start |-> post_sync_active == sync_detected)
        else $error("sync phase wrong");
    c_sync: cover property (sync_detected);
    c_limit_max: cover property (w && reg_wdata[1:0] == 2'h3);
    c_release: cover property ($fell(loops_frozen));
endmodule // bit_sync_checker
bind bit_sync_loop_gain_config bit_sync_checker chk_u (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rdata          (reg_rdata),
    .loops_carrier_gate (loops_carrier_gate),
    .carrier_sense      (carrier_sense),
    .sync_detected      (sync_detected),
    .search_start       (search_start),
    .ki_gain            (ki_gain),
    .kp_gain            (kp_gain),
    .rate_limit         (rate_limit),
    .loops_frozen       (loops_frozen),
    .post_sync_active   (post_sync_active)
);
`default_nettype wire

// [sim/host_model.sv]
// Purpose: host side of the configuration port, one transfer at a time
// Assumes: the block samples address and strobe on the rising edge
// Notes: released write data is inverted so a late capture shows
`default_nettype none
module host_model (
    input  wire logic       ref_clk,
    output var  logic [5:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
    end
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        @(posedge ref_clk) #1;
        d = reg_rdata;
    endtask
endmodule // host_model
`default_nettype wire

// [sim/bit_sync_loop_gain_config_tb.sv]
// Purpose: directed tests of the loop gain configuration block
// Assumes: host_model drives the register port
// Notes: carrier sense moves 1 ns after an edge, as an async source
`default_nettype none
module bit_sync_loop_gain_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, gate = 1'b1, cs = 1'b0, sync = 1'b0, search = 1'b0;
    logic [5:0] reg_addr, ki_gain, kp_gain;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [9:0] rate_limit;
    logic       reg_wr, loops_frozen, post_sync_active;
    int         error_cnt = 0, cmp_count = 0, cycles = 0;
    initial forever #5 ref_clk = ~ref_clk;
    bit_sync_loop_gain_config dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .loops_carrier_gate(gate),
        .carrier_sense(cs), .sync_detected(sync), .search_start(search), .ki_gain(ki_gain),
        .kp_gain(kp_gain), .rate_limit(rate_limit), .loops_frozen(loops_frozen),
        .post_sync_active(post_sync_active));
    host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata));
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic gains(input logic [5:0] ki, input logic [5:0] kp, input logic [9:0] rl);
        chk("ki_gain", 10'(ki), 10'(ki_gain));
        chk("kp_gain", 10'(kp), 10'(kp_gain));
        chk("rate_limit", rl, rate_limit);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // a hang is cut short well past the 42 cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            final_report();
        end
    end
    // ==========
    // tests
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        host_u.read_reg(6'h1a, d);
        chk("reset value", 10'h06c, 10'(d));
        gains(6'h10, 6'h18, 10'h000);
        chk("frozen", 10'h001, 10'(loops_frozen));
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            host_u.write_reg(6'h1a, {2'(i), 2'(i), 2'b00, 2'(i)});
            gains(6'(8 * (i + 1)), 6'(8 * (i + 1)), (i > 0) ? 10'(50 << i) : 10'h000);
        end
        host_u.write_reg(6'h1b, 8'h00);
        host_u.read_reg(6'h1b, d);
        chk("unmapped read", 10'h000, 10'(d));
        host_u.read_reg(6'h1a, d);
        chk("readback", 10'h0f3, 10'(d));
        $display("test codes done");
        host_u.write_reg(6'h1a, 8'h7e);
        @(posedge ref_clk) #1 sync = 1'b1;
        #1 gains(6'h04, 6'h08, 10'h0c8);
        chk("post_sync_active", 10'h001, 10'(post_sync_active));
        @(posedge ref_clk) #1 sync = 1'b0;
        host_u.write_reg(6'h1a, 8'h70);
        gains(6'h10, 6'h20, 10'h000);
        host_u.write_reg(6'h1a, 8'h7c);
        @(posedge ref_clk) #1 search = 1'b1;
        #1 gains(6'h10, 6'h20, 10'h000);
        chk("post_sync_active", 10'h000, 10'(post_sync_active));
        $display("test sync done");
        @(posedge ref_clk) #1 search = 1'b0;
        cs = 1'b1;
        chk("frozen", 10'h001, 10'(loops_frozen));
        repeat (2) @(posedge ref_clk);
        #1 chk("frozen", 10'h000, 10'(loops_frozen));
        cs = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk("frozen latched", 10'h000, 10'(loops_frozen));
        search = 1'b1;
        @(posedge ref_clk) #1 search = 1'b0;
        chk("frozen", 10'h001, 10'(loops_frozen));
        gate = 1'b0;
        #1 chk("frozen ungated", 10'h000, 10'(loops_frozen));
        $display("test carrier done");
        final_report();
    end
endmodule // bit_sync_loop_gain_config_tb
`default_nettype wire
